// *** core/scbm_baud_gen.sv ***
// Baud-rate generator: integer and sixteenth-step fractional division of clk_sys.
// Assumes the divisor fields are quasi-static while run is high.
`default_nettype none
`include "scbm_consts.svh"

module scbm_baud_gen #(
   parameter int DIV_W = 4
) (
   input  wire logic             clk_sys,
   input  wire logic             arst_n,
   input  wire logic             run,
   input  wire logic             frac_en,
   input  wire logic             uart_mode,
   input  wire logic [DIV_W-1:0] div_sel,
   input  wire logic [DIV_W-1:0] frac_k,
   output logic                  tick
);

   if (DIV_W != 4) begin : g_chk
      $error("scbm_baud_gen serves a four-bit divisor only");
   end

   logic [4:0] cnt;
   logic [4:0] next_cnt;
   logic [3:0] acc;
   logic [3:0] next_acc;
   logic       next_tick;
   logic [4:0] n_div;
   logic [4:0] frac_sum;
   logic       frac_act;

   // ----------------------------------------------------------------
   // Divider
   // ----------------------------------------------------------------
   always_comb begin
      n_div     = scbm_pkg::scbm_divisor(div_sel);
      // The fraction is ignored outside the UART modes, whatever software left set.
      frac_act  = frac_en && uart_mode && (frac_k != 4'h0) && (n_div > 5'h01);
      frac_sum  = {1'b0, acc} + (`SCBM_FRAC_STEPS - {1'b0, frac_k});
      next_cnt  = cnt;
      next_acc  = acc;
      next_tick = 1'b0;
      if (!run) begin
         next_cnt = 5'h00;
         next_acc = 4'h0;
      end else if (cnt == 5'h00) begin
         next_tick = 1'b1;
         next_cnt  = n_div - 5'h01;
         if (frac_act) begin
            // Carries of the (16-K) accumulator stretch 16-K periods in every sixteen by one cycle.
            next_acc = frac_sum[3:0];
            next_cnt = n_div - 5'h01 + {4'h0, frac_sum[4]};
         end
      end else begin
         next_cnt = cnt - 5'h01;
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         cnt  <= 5'h00;
         acc  <= 4'h0;
         tick <= 1'b0;
      end else begin
         cnt  <= next_cnt;
         acc  <= next_acc;
         tick <= next_tick;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   // The first tick after a start comes at once, so only later periods are measured.
   logic [5:0] gap;
   logic       armed;
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         gap   <= 6'h00;
         armed <= 1'b0;
      end else if (!run) begin
         gap   <= 6'h00;
         armed <= 1'b0;
      end else if (tick) begin
         gap   <= 6'h00;
         armed <= 1'b1;
      end else begin
         gap   <= gap + 6'h01;
      end
   end

   a_integer_period: assert property (@(posedge clk_sys) disable iff (!arst_n)
      (tick && !frac_act && $past(run) && $stable(div_sel) && $past(tick) == 1'b0
       && armed)
      |-> (gap + 6'h01 == {1'b0, scbm_pkg::scbm_divisor(div_sel)}))
      else $error("integer period differs from divisor");

   a_frac_period: assert property (@(posedge clk_sys) disable iff (!arst_n)
      (tick && armed && $stable(div_sel))
      |-> (gap + 6'h01 >= {1'b0, scbm_pkg::scbm_divisor(div_sel)}
           && gap + 6'h01 <= {1'b0, scbm_pkg::scbm_divisor(div_sel)} + 6'h01))
      else $error("period outside divisor and divisor plus one");

   a_no_tick_stopped: assert property (@(posedge clk_sys) disable iff (!arst_n)
      !run ##1 !run |-> !tick)
      else $error("tick while generator stopped");

endmodule
`default_nettype wire

// *** core/scbm_consts.svh ***
// Offsets, field positions, reset values and timing counts of the serial channel block.
// Assumes inclusion by its bare name from the files under core/.
`ifndef SCBM_CONSTS_SVH
`define SCBM_CONSTS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define SCBM_OFS_MODE_CTRL1_CH0 8'hC5
`define SCBM_OFS_MODE_CTRL1_CH1 8'hCD
`define SCBM_OFS_BUFFER_CH1     8'hC8
`define SCBM_OFS_MODE_CTRL0_CH1 8'hC9
`define SCBM_OFS_BAUD_CTRL      8'hCA
`define SCBM_OFS_BAUD_FRAC      8'hCB
`define SCBM_OFS_INT_STATUS     8'hCE
`define SCBM_OFS_INT_MASK       8'hCF

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SCBM_BIT_IDLE_RUN       7
`define SCBM_BIT_FULL_DUPLEX    6
`define SCBM_BIT_CLK_INPUT      7
`define SCBM_BIT_RX_ENABLE      5
`define SCBM_BIT_FRAC_ENABLE    6
`define SCBM_BIT_TX_DONE        0
`define SCBM_BIT_RX_DONE        1

// ----------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------
`define SCBM_RST_BYTE           8'h00
`define SCBM_FRAC_STEPS         5'h10
`define SCBM_FRAME_BITS         4'h8

`endif

// *** core/scbm_link_if.sv ***
// Carrier between the register side and the shift engine.
// Assumes one clock domain; all members change after the rising edge of clk_sys.
`default_nettype none

interface scbm_link_if;
   logic       tick;
   logic       enable;
   logic       ext_clk;
   logic       full_duplex;
   logic       rx_en;
   logic       tx_load;
   logic       rx_read;
   logic [7:0] tx_data;
   logic [7:0] rx_data;
   logic       tx_done;
   logic       rx_done;
   logic       busy;

   modport ctl (output tick, enable, ext_clk, full_duplex, rx_en, tx_load, rx_read, tx_data,
                input  rx_data, tx_done, rx_done, busy);
   modport shf (input  tick, enable, ext_clk, full_duplex, rx_en, tx_load, rx_read, tx_data,
                output rx_data, tx_done, rx_done, busy);
endinterface

`default_nettype wire

// *** core/scbm_pkg.sv ***
// Types and shared decoding of the serial channel block.
// Assumes scbm_consts.svh is reachable on the include path.
`default_nettype none
`include "scbm_consts.svh"

package scbm_pkg;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      SCBM_MODE_SHIFT = 2'h0,
      SCBM_MODE_UART7 = 2'h1,
      SCBM_MODE_UART8 = 2'h2,
      SCBM_MODE_UART9 = 2'h3
   } scbm_mode_e;

   typedef enum logic [1:0] {
      SCBM_ST_IDLE  = 2'h1,
      SCBM_ST_SHIFT = 2'h2
   } scbm_state_e;

   // ----------------------------------------------------------------
   // Functions
   // ----------------------------------------------------------------
   // Code zero stands for the largest divisor, sixteen.
   function automatic logic [4:0] scbm_divisor(input logic [3:0] sel);
      scbm_divisor = (sel == 4'h0) ? `SCBM_FRAC_STEPS : {1'b0, sel};
   endfunction

endpackage
`default_nettype wire

// *** core/scbm_shift_io.sv ***
// Mode 0 shift engine: eight-bit synchronous transfers with driven or accepted shift clock.
// Assumes sclk_in and rxd are synchronous to clk_sys; transmit on falling, sample on rising.
`default_nettype none
`include "scbm_consts.svh"

module scbm_shift_io (
   input  wire logic  clk_sys,
   input  wire logic  arst_n,
   scbm_link_if.shf   lnk,
   input  wire logic  sclk_in,
   input  wire logic  rxd,
   output logic       txd,
   output logic       sclk_out,
   output logic       sclk_oe
);

   scbm_pkg::scbm_state_e state, next_state;
   logic [7:0] sh_tx, next_sh_tx, sh_rx, next_sh_rx, rx_buf, next_rx_buf, tx_hold, next_tx_hold;
   logic [3:0] bits, next_bits;
   logic       tx_pend, next_tx_pend, rx_free, next_rx_free, do_tx, next_do_tx;
   logic       do_rx, next_do_rx, next_txd, next_sclk_out, next_sclk_oe;
   logic       next_tx_done, next_rx_done, sclk_in_q, rise, fall, want_rx;

   // ----------------------------------------------------------------
   // Engine
   // ----------------------------------------------------------------
   always_comb begin
      // Rising and falling shift-clock moments, generated or taken from the pin.
      rise = lnk.ext_clk ? (sclk_in && !sclk_in_q) : (lnk.tick && !sclk_out);
      fall = lnk.ext_clk ? (!sclk_in && sclk_in_q) : (lnk.tick && sclk_out);
      want_rx       = lnk.rx_en && rx_free;
      next_state    = state;
      next_sh_tx    = sh_tx;
      next_sh_rx    = sh_rx;
      next_rx_buf   = rx_buf;
      next_tx_hold  = lnk.tx_load ? lnk.tx_data : tx_hold;
      next_bits     = bits;
      next_tx_pend  = tx_pend || lnk.tx_load;
      next_rx_free  = rx_free || lnk.rx_read;
      next_do_tx    = do_tx;
      next_do_rx    = do_rx;
      next_txd      = txd;
      next_sclk_out = sclk_out;
      next_sclk_oe  = lnk.enable && !lnk.ext_clk;
      next_tx_done  = 1'b0;
      next_rx_done  = 1'b0;
      unique case (state)
         scbm_pkg::SCBM_ST_IDLE: begin
            next_sclk_out = 1'b1;
            if (lnk.enable && (tx_pend || want_rx)) begin
               next_state   = scbm_pkg::SCBM_ST_SHIFT;
               next_do_tx   = tx_pend;
               // Half duplex lets a pending transmit keep the line to itself.
               next_do_rx   = want_rx && (lnk.full_duplex || !tx_pend);
               next_tx_pend = lnk.tx_load;
               next_sh_tx   = tx_hold;
               next_bits    = 4'h0;
               if (tx_pend) begin
                  next_txd = tx_hold[0];
               end
            end
         end
         scbm_pkg::SCBM_ST_SHIFT: begin
            if (!lnk.enable) begin
               next_state = scbm_pkg::SCBM_ST_IDLE;
            end else begin
               if (!lnk.ext_clk && lnk.tick) begin
                  next_sclk_out = !sclk_out;
               end
               if (fall && bits != 4'h0 && do_tx) begin
                  next_txd = sh_tx[0];
               end
               if (rise) begin
                  next_sh_rx = {rxd, sh_rx[7:1]};
                  next_sh_tx = {1'b1, sh_tx[7:1]};
                  next_bits  = bits + 4'h1;
                  if (bits == `SCBM_FRAME_BITS - 4'h1) begin
                     next_state   = scbm_pkg::SCBM_ST_IDLE;
                     next_tx_done = do_tx;
                     next_rx_done = do_rx;
                     if (do_rx) begin
                        next_rx_buf  = {rxd, sh_rx[7:1]};
                        next_rx_free = lnk.rx_read;
                     end
                  end
               end
            end
         end
         default: next_state = scbm_pkg::SCBM_ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         state    <= scbm_pkg::SCBM_ST_IDLE;
         sh_tx    <= `SCBM_RST_BYTE;
         sh_rx    <= `SCBM_RST_BYTE;
         rx_buf   <= `SCBM_RST_BYTE;
         tx_hold  <= `SCBM_RST_BYTE;
         bits     <= 4'h0;
         tx_pend  <= 1'b0;
         rx_free  <= 1'b1;
         do_tx    <= 1'b0;
         do_rx    <= 1'b0;
         txd      <= 1'b1;
         sclk_out <= 1'b1;
         sclk_oe  <= 1'b0;
         sclk_in_q <= 1'b1;
         lnk.tx_done <= 1'b0;
         lnk.rx_done <= 1'b0;
      end else begin
         state    <= next_state;
         sh_tx    <= next_sh_tx;
         sh_rx    <= next_sh_rx;
         rx_buf   <= next_rx_buf;
         tx_hold  <= next_tx_hold;
         bits     <= next_bits;
         tx_pend  <= next_tx_pend;
         rx_free  <= next_rx_free;
         do_tx    <= next_do_tx;
         do_rx    <= next_do_rx;
         txd      <= next_txd;
         sclk_out <= next_sclk_out;
         sclk_oe  <= next_sclk_oe;
         sclk_in_q <= sclk_in;
         lnk.tx_done <= next_tx_done;
         lnk.rx_done <= next_rx_done;
      end
   end

   assign lnk.rx_data = rx_buf;
   assign lnk.busy    = (state == scbm_pkg::SCBM_ST_SHIFT);

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_done_after_eight: assert property (@(posedge clk_sys) disable iff (!arst_n)
      $rose(lnk.tx_done)
      |-> $past(bits) == 4'h7 && $past(state) == scbm_pkg::SCBM_ST_SHIFT)
      else $error("transmit done without eight bits");

   a_done_pulse: assert property (@(posedge clk_sys) disable iff (!arst_n)
      lnk.tx_done |=> !lnk.tx_done)
      else $error("transmit done longer than one cycle");

   // The edge of reset release still shows reset values, so it is left out.
   a_sclk_drive: assert property (@(posedge clk_sys) disable iff (!arst_n)
      $past(arst_n) |-> (sclk_oe == $past(lnk.enable && !lnk.ext_clk)))
      else $error("shift clock enable mismatched to clock option");

endmodule
`default_nettype wire

// *** core/scbm_top.sv ***
// Serial channel baud generator and mode control with the mode 0 shift interface.
// Assumes a single-cycle register port on clk_sys and pins synchronous to clk_sys.
//
// How it works
// - Integer divisor N from 1 to 16; code 0000 means sixteen.
// - With fraction enabled, K nonzero and N from 2 to 16, divide by N plus (16-K)/16.
// - Fractional division acts only in UART modes, never in mode 0.
// - Mode control 1 bit 7 selects stop or run in idle; resets 0.
// - Mode control 1 bit 6 selects half or full duplex; resets 0.
// - Mode 0 shifts bytes to or from an external shift register.
// - Mode 0 drives the shift clock out or accepts it from outside.
// - A buffer write shifts eight bits out, then sets transmit done.
`default_nettype none
`include "scbm_consts.svh"

module scbm_top (
   input  wire logic       clk_sys,
   input  wire logic       arst_n,
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic      [7:0] reg_rdata,
   input  wire logic       low_power_idle_state,
   output logic            ch0_stopped,
   output logic            irq,
   input  wire logic       sclk_in,
   input  wire logic       rxd,
   output logic            txd,
   output logic            sclk_out,
   output logic            sclk_oe
);

   scbm_link_if lnk ();

   logic [7:0] serial0_mode_control_1, next_mode1_ch0;
   logic [7:0] serial1_mode_control_1, next_mode1_ch1;
   logic [7:0] mode_control_0, next_mode0;
   logic [7:0] baud_gen_control, next_baud_ctl;
   logic [7:0] baud_fraction_register, next_baud_frac;
   logic [7:0] int_status, next_int_status;
   logic [7:0] int_mask, next_int_mask;
   logic [7:0] next_rdata;
   logic       next_irq, next_ch0_stopped, ch1_run, mode_shift;
   scbm_pkg::scbm_mode_e mode;

   // ----------------------------------------------------------------
   // Channel control
   // ----------------------------------------------------------------
   always_comb begin
      mode       = scbm_pkg::scbm_mode_e'(mode_control_0[1:0]);
      mode_shift = (mode == scbm_pkg::SCBM_MODE_SHIFT);
      // Idle with the run bit clear stops the channel and clears its divider count.
      ch1_run    = !low_power_idle_state
                   || serial1_mode_control_1[`SCBM_BIT_IDLE_RUN];
   end

   scbm_baud_gen #(
      .DIV_W (4)
   ) u_baud (
      .clk_sys   (clk_sys),
      .arst_n    (arst_n),
      .run       (ch1_run),
      .frac_en   (baud_gen_control[`SCBM_BIT_FRAC_ENABLE]),
      .uart_mode (!mode_shift),
      .div_sel   (baud_gen_control[3:0]),
      .frac_k    (baud_fraction_register[3:0]),
      .tick      (lnk.tick)
   );

   assign lnk.enable      = mode_shift && ch1_run;
   assign lnk.ext_clk     = mode_control_0[`SCBM_BIT_CLK_INPUT];
   assign lnk.full_duplex = serial1_mode_control_1[`SCBM_BIT_FULL_DUPLEX];
   assign lnk.rx_en       = mode_control_0[`SCBM_BIT_RX_ENABLE];
   assign lnk.tx_load     = reg_wr && (reg_addr == `SCBM_OFS_BUFFER_CH1);
   assign lnk.tx_data     = reg_wdata;
   assign lnk.rx_read     = reg_rd && (reg_addr == `SCBM_OFS_BUFFER_CH1);

   scbm_shift_io u_shift (
      .clk_sys  (clk_sys),
      .arst_n   (arst_n),
      .lnk      (lnk),
      .sclk_in  (sclk_in),
      .rxd      (rxd),
      .txd      (txd),
      .sclk_out (sclk_out),
      .sclk_oe  (sclk_oe)
   );

   // ----------------------------------------------------------------
   // Register file
   // ----------------------------------------------------------------
   always_comb begin
      next_mode1_ch0  = serial0_mode_control_1;
      next_mode1_ch1  = serial1_mode_control_1;
      next_mode0      = mode_control_0;
      next_baud_ctl   = baud_gen_control;
      next_baud_frac  = baud_fraction_register;
      next_int_mask   = int_mask;
      next_int_status = int_status;
      if (reg_wr) begin
         unique case (reg_addr)
            `SCBM_OFS_MODE_CTRL1_CH0: next_mode1_ch0 = {reg_wdata[7:6], 6'h00};
            `SCBM_OFS_MODE_CTRL1_CH1: next_mode1_ch1 = {reg_wdata[7:6], 6'h00};
            `SCBM_OFS_MODE_CTRL0_CH1: next_mode0     = {reg_wdata[7], 1'b0, reg_wdata[5],
                                                        3'h0, reg_wdata[1:0]};
            `SCBM_OFS_BAUD_CTRL:      next_baud_ctl  = {1'b0, reg_wdata[6], 2'h0,
                                                        reg_wdata[3:0]};
            `SCBM_OFS_BAUD_FRAC:      next_baud_frac = {4'h0, reg_wdata[3:0]};
            `SCBM_OFS_INT_MASK:       next_int_mask  = {6'h00, reg_wdata[1:0]};
            `SCBM_OFS_INT_STATUS:     next_int_status = int_status & ~reg_wdata;
            default: begin
            end
         endcase
      end
      // A completion in the cycle of its own clearing still lands.
      if (lnk.tx_done) begin
         next_int_status[`SCBM_BIT_TX_DONE] = 1'b1;
      end
      if (lnk.rx_done) begin
         next_int_status[`SCBM_BIT_RX_DONE] = 1'b1;
      end
      next_irq         = |(next_int_status & next_int_mask);
      next_ch0_stopped = low_power_idle_state
                         && !serial0_mode_control_1[`SCBM_BIT_IDLE_RUN];
      next_rdata       = 8'h00;
      if (reg_rd) begin
         unique case (reg_addr)
            `SCBM_OFS_MODE_CTRL1_CH0: next_rdata = serial0_mode_control_1;
            `SCBM_OFS_MODE_CTRL1_CH1: next_rdata = serial1_mode_control_1;
            `SCBM_OFS_MODE_CTRL0_CH1: next_rdata = mode_control_0;
            `SCBM_OFS_BAUD_CTRL:      next_rdata = baud_gen_control;
            `SCBM_OFS_BAUD_FRAC:      next_rdata = baud_fraction_register;
            // Reads give received data, not what was written, hence no read-modify-write.
            `SCBM_OFS_BUFFER_CH1:     next_rdata = lnk.rx_data;
            `SCBM_OFS_INT_STATUS:     next_rdata = int_status;
            `SCBM_OFS_INT_MASK:       next_rdata = int_mask;
            default:                  next_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         serial0_mode_control_1 <= `SCBM_RST_BYTE;
         serial1_mode_control_1 <= `SCBM_RST_BYTE;
         mode_control_0         <= `SCBM_RST_BYTE;
         baud_gen_control       <= `SCBM_RST_BYTE;
         baud_fraction_register <= `SCBM_RST_BYTE;
         int_status             <= `SCBM_RST_BYTE;
         int_mask               <= `SCBM_RST_BYTE;
         reg_rdata              <= `SCBM_RST_BYTE;
         irq                    <= 1'b0;
         ch0_stopped            <= 1'b0;
      end else begin
         serial0_mode_control_1 <= next_mode1_ch0;
         serial1_mode_control_1 <= next_mode1_ch1;
         mode_control_0         <= next_mode0;
         baud_gen_control       <= next_baud_ctl;
         baud_fraction_register <= next_baud_frac;
         int_status             <= next_int_status;
         int_mask               <= next_int_mask;
         reg_rdata              <= next_rdata;
         irq                    <= next_irq;
         ch0_stopped            <= next_ch0_stopped;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_mode1_readback: assert property (@(posedge clk_sys) disable iff (!arst_n)
      reg_wr && reg_addr == `SCBM_OFS_MODE_CTRL1_CH0 ##1 !reg_wr
      ##1 reg_rd && reg_addr == `SCBM_OFS_MODE_CTRL1_CH0
      |=> reg_rdata == ($past(reg_wdata, 3) & 8'hC0))
      else $error("mode control 1 readback wrong");

   a_idle_stop: assert property (@(posedge clk_sys) disable iff (!arst_n)
      low_power_idle_state && !serial1_mode_control_1[`SCBM_BIT_IDLE_RUN]
      [*2] |-> !lnk.tick)
      else $error("channel ran in idle with run bit clear");

   a_done_sets_flag: assert property (@(posedge clk_sys) disable iff (!arst_n)
      lnk.tx_done |=> int_status[`SCBM_BIT_TX_DONE]
      && (irq || !int_mask[`SCBM_BIT_TX_DONE]))
      else $error("transmit done flag or interrupt missing");

   a_done_from_busy: assert property (@(posedge clk_sys) disable iff (!arst_n)
      lnk.tx_done |-> $past(lnk.busy))
      else $error("transmit done without a transfer");

   // The level follows the registered status and mask with no extra lag.
   a_irq_level: assert property (@(posedge clk_sys) disable iff (!arst_n)
      irq == (|(int_status & int_mask)))
      else $error("interrupt level disagrees with status and mask");

endmodule
`default_nettype wire

// *** tb/scbm_shift_partner.sv ***
// External shift register on the mode 0 link.
// Assumes sclk idles high and moves on clk_sys edges only.
`default_nettype none
module scbm_shift_partner (
   input  wire logic       clk_sys,
   input  wire logic       sclk,
   input  wire logic       txd,
   input  wire logic [7:0] tx_byte,
   output logic            rxd,
   output logic      [7:0] got
);
   timeunit 1ns;
   timeprecision 100ps;
   logic       sclk_q = 1'b1;
   logic       rxd_q  = 1'b1;
   logic [2:0] idx    = 3'h0;
   assign rxd = rxd_q;
   // Between frames rxd toggles, so a stale bit never passes for data.
   always @(posedge clk_sys) begin
      sclk_q <= sclk;
      if (sclk && !sclk_q) {got, idx} <= {txd, got[7:1], idx + 3'h1};
      if (!sclk && sclk_q) rxd_q <= tx_byte[idx];
      if (sclk && sclk_q && idx == 3'h0) rxd_q <= ~rxd_q;
   end
endmodule
`default_nettype wire

// *** tb/test_serial_channel_baud_and_mode_control.sv ***
// Bench of the serial channel block: registers, interrupt and mode 0 link.
// Assumes the core files and scbm_shift_partner are compiled first.
`default_nettype none
module test_serial_channel_baud_and_mode_control;
   timeunit 1ns;
   timeprecision 100ps;
   logic       clk_sys = 1'b0, arst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, rd_q = 1'b0;
   logic       idle = 1'b0, sclk_in = 1'b1, rxd, txd, sclk_out, sclk_oe, ch0_stopped, irq;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, pbyte = 8'h00, got, b, eq[$];
   int         n_mismatch = 0, tests_run = 0, half = 16, cnt = 0, seed = 31;
   localparam logic [7:0] ofs [5] = '{8'hCF, 8'hCD, 8'hCB, 8'hCA, 8'hC9};
   always #12.5 clk_sys = ~clk_sys;
   always @(posedge clk_sys) rd_q <= reg_rd;
   scbm_top DUT (.clk_sys(clk_sys), .arst_n(arst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .low_power_idle_state(idle), .ch0_stopped(ch0_stopped), .irq(irq), .sclk_in(sclk_in),
      .rxd(rxd), .txd(txd), .sclk_out(sclk_out), .sclk_oe(sclk_oe));
   scbm_shift_partner ext (.clk_sys(clk_sys), .sclk(sclk_oe ? sclk_out : sclk_in),
      .txd(txd), .tx_byte(pbyte), .rxd(rxd), .got(got));
   task automatic check(input logic [7:0] seen, input logic [7:0] want, input string what);
      tests_run++;
      if (seen !== want) n_mismatch++;
      if (seen !== want) $display("BAD %s expected %h seen %h", what, want, seen);
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
      if (!w) eq.push_back(d);
      reg_addr <= a;
      reg_wdata <= d;
      {reg_wr, reg_rd} <= {w, !w};
      @(posedge clk_sys) {reg_wr, reg_rd} <= 2'b00;
      @(posedge clk_sys);
   endtask
   task automatic setup(input logic [7:0] v [5]);
      foreach (v[i]) bus(1'b1, ofs[i], v[i]);
   endtask
   task automatic print_verdict();
      $display("compares %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   always @(negedge clk_sys) begin
      if (rd_q) check(reg_rdata, eq.pop_front(), "rdata");
      else check(reg_rdata, 8'h00, "rdata idle");
      if (sclk_out && cnt != 0) check(8'(cnt), 8'(half), "sclk");
      cnt = (sclk_out === 1'b0) ? cnt + 1 : 0;
   end
   initial begin
      #150us n_mismatch++;
      print_verdict();
   end
   initial begin
      repeat (6) @(posedge clk_sys);
      arst_n <= 1'b1;
      b = 8'($random(seed));
      pbyte <= 8'($random(seed));
      idle <= 1'b1;
      bus(1'b0, 8'hC5, 8'h00);
      bus(1'b0, 8'hD3, 8'h00);
      bus(1'b1, 8'hC5, b);
      bus(1'b0, 8'hC5, b & 8'hC0);
      check({7'h0, ch0_stopped}, {7'h0, ~b[7]}, "stop");
      idle <= 1'b0;
      setup('{8'h00, 8'h80, 8'h08, 8'h40, 8'h20});
      bus(1'b1, 8'hC8, b);
      check({7'h0, sclk_oe}, 8'h01, "oe");
      repeat (600) @(posedge clk_sys);
      check({7'h0, irq}, 8'h00, "irq");
      check(got, b, "got");
      bus(1'b0, 8'hCD, 8'h80);
      bus(1'b1, 8'hC9, 8'h00);
      bus(1'b0, 8'hC8, pbyte);
      bus(1'b0, 8'hCE, 8'h03);
      bus(1'b1, 8'hCF, 8'h01);
      check({7'h0, irq}, 8'h01, "irq");
      bus(1'b1, 8'hCE, 8'h03);
      check({7'h0, irq}, 8'h00, "irq");
      setup('{8'h00, 8'h80, 8'h08, 8'h00, 8'h80});
      bus(1'b1, 8'hC8, ~b);
      check({7'h0, sclk_oe}, 8'h00, "oe");
      repeat (17) begin
         repeat (4) @(posedge clk_sys);
         sclk_in <= ~sclk_in;
      end
      check(got, ~b, "got");
      print_verdict();
   end
endmodule
`default_nettype wire
